// [inc/arb_pkg.sv]
/*
 * Constants, types and register layout shared by the serial line arbiter timer.
 * Assumes a byte-wide register port with a two-bit word address.
 */
package arb_pkg;
	// Register addresses (word index on the plain register port).
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_COUNT = 2'h1;
	// Control register bit positions.
	localparam int B_MODE_HI = 7;
	localparam int B_MODE_LO = 6;
	localparam int B_CLK_SEL = 5;
	localparam int B_DONE = 4;
	localparam int B_RUN = 3;
	localparam int B_OVF = 2;
	localparam int B_TOP = 1;
	localparam int B_LOST = 0;
	// Arbiter modes.
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_MEAS = 2'h1;
	localparam logic [1:0] MODE_ARB = 2'h2;
	localparam logic [1:0] MODE_RSVD = 2'h3;
	// Counter values.
	localparam logic [8:0] CNT_RESET = 9'h000;
	localparam logic [8:0] CNT_ONE = 9'h001;
	localparam logic [8:0] CNT_MAX = 9'h1FF;
	localparam logic [8:0] SAMPLE_BUS = 9'h038;
	localparam logic [8:0] SAMPLE_PRESC = 9'h008;
	// Reset and idle values of the register port.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int SYNC_W = 3;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ARMED = 4'b0010,
		ST_RUN = 4'b0100,
		ST_HALT = 4'b1000
	} arb_state_t;

	typedef struct packed {
		logic rx;
		logic tx;
		logic presc;
	} line_t;

	typedef struct packed {
		logic [1:0] mode;
		logic clk_sel;
	} ctrl_t;
endpackage

// [hw/sync2.sv]
/*
 * Two-flop synchroniser for a group of slow single-bit levels.
 * Assumes the inputs are levels; the first stage feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= '0;
			q_out <= '0;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule // sync2
`default_nettype wire

// [hw/serial_line_arbiter_timer.sv]
/*
 * Arbiter timer for an enhanced serial interface: 9-bit counter for bit time
 * and break measurement, and bus arbitration that guards the transmit pin.
 * Assumes rx, transmit and prescaler clock inputs are slow against mclk_in.
 */
// The register offsets and the plain strobed port were chosen for this implementation.
// How it works
// - Low eight counter bits are readable; reset clears them.
// - Any control register write clears the counter.
// - Mode 00 holds the counter at zero and idle.
// - Clock select 0 counts at half the bus clock.
// - Clock select 0 measurement starts on a receive falling edge.
// - Clock select 0 measurement stops on the next receive falling edge.
// - Running flag while counting; finished flag set when counting stops.
// - Clock select 1 counts at half the prescaler clock.
// - Clock select 1 measurement starts on a low receive level.
// - A receive line already low starts counting at once.
// - Clock select 1 measurement stops on the next receive rising edge.
// - Mode 10 arbitrates; each transmit rising edge restarts the counter.
// - At count 38h or 08h a low receive line sets the lost flag.
// - While lost is set the transmit pin is forced high.
// - Transmit low without prior receive low resets the counter, awaits next rise.
// - Mode codes: 00 idle, 01 measure, 10 arbitrate, 11 reserved.
// - Writing upper mode bit as 0 clears lost; reset clears it.
// - Counter overflow sets a flag cleared by any control write.
// - Counter top bit readable in control; cleared by write and reset.
`timescale 1ns/1ps
`default_nettype none
module serial_line_arbiter_timer (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// Register port
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Serial lines
	input wire logic rxd_in,
	input wire logic txd_int_in,
	input wire logic presc_clk_in,
	output logic txd_pin_out
);
	logic rst_meta_r;
	logic rst_n_r;
	arb_pkg::line_t line_raw;
	arb_pkg::line_t line_s;
	arb_pkg::line_t line_prev_r;
	arb_pkg::ctrl_t ctrl_r;
	arb_pkg::arb_state_t st_r;
	arb_pkg::arb_state_t st_nxt;
	logic [8:0] cnt_r;
	logic [8:0] cnt_nxt;
	logic [8:0] sample_at;
	logic smp_r;
	logic smp_nxt;
	logic done_r;
	logic ovf_r;
	logic lost_r;
	logic lost_nxt;
	logic done_set;
	logic ovf_set;
	logic lost_set;
	logic bus_div_r;
	logic presc_div_r;
	logic tick;
	logic ctrl_wr;
	logic rx_fall;
	logic rx_rise;
	logic tx_rise;
	logic tx_fall;
	logic presc_rise;
	logic running;
	logic [7:0] rdata_r;
	logic txd_pin_r;

	function automatic logic [7:0] ctrl_image(input arb_pkg::ctrl_t c, input logic done,
			input logic run, input logic ovf, input logic top, input logic lost);
		logic [7:0] v;
		v = arb_pkg::CTRL_RESET;
		v[arb_pkg::B_MODE_HI] = c.mode[1];
		v[arb_pkg::B_MODE_LO] = c.mode[0];
		v[arb_pkg::B_CLK_SEL] = c.clk_sel;
		v[arb_pkg::B_DONE] = done;
		v[arb_pkg::B_RUN] = run;
		v[arb_pkg::B_OVF] = ovf;
		v[arb_pkg::B_TOP] = top;
		v[arb_pkg::B_LOST] = lost;
		return v;
	endfunction

	// Reset is asserted at once and released through two flops.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	assign line_raw = '{rx: rxd_in, tx: txd_int_in, presc: presc_clk_in};

	// Edges are taken only from the second stage so each acts once.
	sync2 #(
		.W(arb_pkg::SYNC_W)
	) u_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_r),
		.d_in(line_raw),
		.q_out(line_s)
	);

	always_ff @(posedge mclk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			line_prev_r <= '0;
		end else begin
			line_prev_r <= line_s;
		end
	end

	assign rx_fall = line_prev_r.rx && !line_s.rx;
	assign rx_rise = !line_prev_r.rx && line_s.rx;
	assign tx_rise = !line_prev_r.tx && line_s.tx;
	assign tx_fall = line_prev_r.tx && !line_s.tx;
	assign presc_rise = !line_prev_r.presc && line_s.presc;
	assign ctrl_wr = wr_in && (addr_in == arb_pkg::ADDR_CTRL);
	assign running = (st_r == arb_pkg::ST_RUN);

	// Counter clock dividers; a tick is one counter clock period.
	always_ff @(posedge mclk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			bus_div_r <= 1'b0;
			presc_div_r <= 1'b0;
		end else begin
			bus_div_r <= !bus_div_r;
			if (presc_rise) begin
				presc_div_r <= !presc_div_r;
			end
		end
	end

	assign tick = ctrl_r.clk_sel ? (presc_rise && presc_div_r) : bus_div_r;
	assign sample_at = ctrl_r.clk_sel ? arb_pkg::SAMPLE_PRESC : arb_pkg::SAMPLE_BUS;

	// Control register holds mode and clock select.
	always_ff @(posedge mclk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= '0;
		end else if (ctrl_wr) begin
			ctrl_r.mode <= wdata_in[arb_pkg::B_MODE_HI:arb_pkg::B_MODE_LO];
			ctrl_r.clk_sel <= wdata_in[arb_pkg::B_CLK_SEL];
		end
	end

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		smp_nxt = smp_r;
		done_set = 1'b0;
		ovf_set = 1'b0;
		lost_set = 1'b0;
		if (tick && running) begin
			cnt_nxt = cnt_r + arb_pkg::CNT_ONE;
			ovf_set = (cnt_r == arb_pkg::CNT_MAX);
		end
		case (ctrl_r.mode)
			arb_pkg::MODE_MEAS: begin
				case (st_r)
					arb_pkg::ST_IDLE, arb_pkg::ST_ARMED: begin
						// A low level also covers a line already low at enable.
						if (ctrl_r.clk_sel ? !line_s.rx : rx_fall) begin
							st_nxt = arb_pkg::ST_RUN;
							cnt_nxt = arb_pkg::CNT_RESET;
						end else begin
							st_nxt = arb_pkg::ST_ARMED;
						end
					end
					arb_pkg::ST_RUN: begin
						if (ctrl_r.clk_sel ? rx_rise : rx_fall) begin
							st_nxt = arb_pkg::ST_HALT;
							cnt_nxt = cnt_r;
							done_set = 1'b1;
							ovf_set = 1'b0;
						end
					end
					arb_pkg::ST_HALT: begin
						st_nxt = arb_pkg::ST_HALT;
					end
					default: begin
						st_nxt = arb_pkg::ST_IDLE;
					end
				endcase
			end
			arb_pkg::MODE_ARB: begin
				if (tx_rise) begin
					st_nxt = arb_pkg::ST_RUN;
					cnt_nxt = arb_pkg::CNT_RESET;
					smp_nxt = 1'b1;
				end else if (tx_fall && !lost_r) begin
					st_nxt = arb_pkg::ST_ARMED;
					cnt_nxt = arb_pkg::CNT_RESET;
					smp_nxt = 1'b0;
				end else if (running && smp_r && cnt_r == sample_at) begin
					smp_nxt = 1'b0;
					lost_set = !line_s.rx;
				end else if (st_r == arb_pkg::ST_IDLE) begin
					st_nxt = arb_pkg::ST_ARMED;
				end
			end
			default: begin
				// Reserved mode is treated as idle so nothing can run unmanaged.
				st_nxt = arb_pkg::ST_IDLE;
				cnt_nxt = arb_pkg::CNT_RESET;
				smp_nxt = 1'b0;
			end
		endcase
		if (ctrl_wr) begin
			st_nxt = arb_pkg::ST_IDLE;
			cnt_nxt = arb_pkg::CNT_RESET;
			smp_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= arb_pkg::ST_IDLE;
			cnt_r <= arb_pkg::CNT_RESET;
			smp_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			smp_r <= smp_nxt;
		end
	end

	// Hardware set wins over a clearing write in the same cycle.
	always_ff @(posedge mclk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			done_r <= 1'b0;
			ovf_r <= 1'b0;
		end else begin
			done_r <= done_set || (done_r && !ctrl_wr);
			ovf_r <= ovf_set || (ovf_r && !ctrl_wr);
		end
	end

	assign lost_nxt = lost_set || (lost_r && !(ctrl_wr && !wdata_in[arb_pkg::B_MODE_HI]));

	always_ff @(posedge mclk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			lost_r <= 1'b0;
			txd_pin_r <= 1'b1;
		end else begin
			lost_r <= lost_nxt;
			txd_pin_r <= lost_nxt || line_s.tx;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_r <= arb_pkg::READ_ZERO;
		end else if (rd_in) begin
			case (addr_in)
				arb_pkg::ADDR_CTRL: begin
					rdata_r <= ctrl_image(ctrl_r, done_r, running, ovf_r, cnt_r[8], lost_r);
				end
				arb_pkg::ADDR_COUNT: begin
					rdata_r <= cnt_r[7:0];
				end
				default: begin
					rdata_r <= arb_pkg::READ_ZERO;
				end
			endcase
		end else begin
			rdata_r <= arb_pkg::READ_ZERO;
		end
	end

	assign rdata_out = rdata_r;
	assign txd_pin_out = txd_pin_r;

	logic meas0;
	logic meas1;
	assign meas0 = (ctrl_r.mode == arb_pkg::MODE_MEAS) && !ctrl_r.clk_sel;
	assign meas1 = (ctrl_r.mode == arb_pkg::MODE_MEAS) && ctrl_r.clk_sel;

	property p_count_read;
		@(posedge mclk_in) disable iff (!rst_n_r)
		rd_in && addr_in == arb_pkg::ADDR_COUNT |=> rdata_out == $past(cnt_r[7:0]);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read mismatch");

	property p_wr_clear;
		@(posedge mclk_in) disable iff (!rst_n_r)
		ctrl_wr |=> cnt_r == arb_pkg::CNT_RESET && (!ovf_r || $past(ovf_set));
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("write did not clear");

	property p_idle;
		@(posedge mclk_in) disable iff (!rst_n_r)
		ctrl_r.mode == arb_pkg::MODE_IDLE && !ctrl_wr |=> cnt_r == arb_pkg::CNT_RESET && !running;
	endproperty
	a_idle: assert property (p_idle) else $error("idle counter moved");

	property p_half_rate;
		@(posedge mclk_in) disable iff (!rst_n_r)
		meas0 && running && !ctrl_wr && cnt_r == $past(cnt_r) + arb_pkg::CNT_ONE
		|=> cnt_r == $past(cnt_r) || ctrl_wr;
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("counted faster than half");

	property p_start_fall;
		@(posedge mclk_in) disable iff (!rst_n_r)
		meas0 && !ctrl_wr && st_r == arb_pkg::ST_ARMED && rx_fall |=> running;
	endproperty
	a_start_fall: assert property (p_start_fall) else $error("no start on fall");

	property p_stop_fall;
		@(posedge mclk_in) disable iff (!rst_n_r)
		meas0 && !ctrl_wr && running && rx_fall |=> !running && done_r;
	endproperty
	a_stop_fall: assert property (p_stop_fall) else $error("no stop on fall");

	property p_start_low;
		@(posedge mclk_in) disable iff (!rst_n_r)
		meas1 && !ctrl_wr && !running && st_r != arb_pkg::ST_HALT && !line_s.rx |=> running;
	endproperty
	a_start_low: assert property (p_start_low) else $error("no start on low");

	property p_stop_rise;
		@(posedge mclk_in) disable iff (!rst_n_r)
		meas1 && !ctrl_wr && running && rx_rise |=> done_r && !running;
	endproperty
	a_stop_rise: assert property (p_stop_rise) else $error("no stop on rise");

	property p_arb_restart;
		@(posedge mclk_in) disable iff (!rst_n_r)
		ctrl_r.mode == arb_pkg::MODE_ARB && !ctrl_wr && tx_rise |=> running && cnt_r == arb_pkg::CNT_RESET;
	endproperty
	a_arb_restart: assert property (p_arb_restart) else $error("no restart");

	property p_lost_set;
		@(posedge mclk_in) disable iff (!rst_n_r)
		ctrl_r.mode == arb_pkg::MODE_ARB && running && smp_r && cnt_r == sample_at && !line_s.rx
		&& !tx_rise && !tx_fall |=> lost_r;
	endproperty
	a_lost_set: assert property (p_lost_set) else $error("lost not set");

	property p_pin_forced;
		@(posedge mclk_in) disable iff (!rst_n_r)
		lost_r |-> txd_pin_out;
	endproperty
	a_pin_forced: assert property (p_pin_forced) else $error("pin not forced high");

	property p_lost_clear;
		@(posedge mclk_in) disable iff (!rst_n_r)
		ctrl_wr && !wdata_in[arb_pkg::B_MODE_HI] && !lost_set |=> !lost_r;
	endproperty
	a_lost_clear: assert property (p_lost_clear) else $error("lost not cleared");

	c_measure_done: cover property (@(posedge mclk_in) disable iff (!rst_n_r) meas0 && $rose(done_r));
	c_break_done: cover property (@(posedge mclk_in) disable iff (!rst_n_r) meas1 && $rose(done_r));
	c_lost: cover property (@(posedge mclk_in) disable iff (!rst_n_r) $rose(lost_r));
	c_overflow: cover property (@(posedge mclk_in) disable iff (!rst_n_r) $rose(ovf_r));
endmodule // serial_line_arbiter_timer
`default_nettype wire

// [tb/bus_partner.sv]
/*
 * Far side model: the shared serial line, another node on it, the internal
 * transmitter and the free running prescaler clock.
 * Assumes it shares the bench clock and is steered through its tasks.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
	// Clock
	input wire logic mclk_in,
	// Device side
	input wire logic txd_pin_in,
	output logic rxd_out,
	output var logic txd_int_out,
	output var logic presc_out
);
	logic dom_r;
	logic [3:0] div_r;
	initial begin
		dom_r = 1'b0;
		txd_int_out = 1'b1;
		presc_out = 1'b0;
		div_r = 4'h0;
	end
	// The line is pulled up and any node driving low wins, so our own pin loops back.
	assign rxd_out = txd_pin_in & ~dom_r;
	// Ten cycles a phase keeps the prescaler well inside the sampling limit.
	always @(posedge mclk_in) begin
		div_r <= (div_r == 4'h9) ? 4'h0 : div_r + 4'h1;
		if (div_r == 4'h9) begin
			presc_out <= ~presc_out;
		end
	end
	task set_dom(input logic v);
		@(posedge mclk_in);
		dom_r <= v;
	endtask
	task set_tx(input logic v);
		@(posedge mclk_in);
		txd_int_out <= v;
	endtask
endmodule // bus_partner
`default_nettype wire

// [tb/serial_line_arbiter_timer_tb.sv]
/*
 * Self-checking bench for the serial line arbiter timer.
 * Assumes the partner model drives the line inputs and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_line_arbiter_timer_tb;
	logic clk;
	logic rstn;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic we;
	logic re;
	logic [7:0] rdata;
	logic rxd;
	logic txd_int;
	logic presc;
	logic txd_pin;
	int errors = 0;
	int checked = 0;
	int cycles = 0;

	serial_line_arbiter_timer serial_line_arbiter_timer_inst (
		.mclk_in(clk),
		.rstn_in(rstn),
		.addr_in(addr),
		.wdata_in(wdata),
		.wr_in(we),
		.rd_in(re),
		.rdata_out(rdata),
		.rxd_in(rxd),
		.txd_int_in(txd_int),
		.presc_clk_in(presc),
		.txd_pin_out(txd_pin)
	);
	bus_partner bus_partner_inst (
		.mclk_in(clk),
		.txd_pin_in(txd_pin),
		.rxd_out(rxd),
		.txd_int_out(txd_int),
		.presc_out(presc)
	);

	always #2.5 clk = ~clk;
	// The tests need about 2600 cycles; the ceiling leaves ample margin.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("BAD timeout expected 0 seen 1");
			conclude();
		end
	end

	task conclude();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task check8(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Counts are compared with a tolerance that covers the synchroniser phase.
	task near(input string n, input int e, input int tol, input logic [7:0] g);
		checked++;
		if ($isunknown(g) || int'(g) < e - tol || int'(g) > e + tol) begin
			errors++;
			$display("BAD %s expected %0d seen %h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task reg_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		d = rdata;
	endtask
	task rd_chk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
		logic [7:0] v;
		reg_rd(a, v);
		check8(n, e, v & m);
	endtask
	task rd_near(input int e, input int tol);
		logic [7:0] v;
		reg_rd(arb_pkg::ADDR_COUNT, v);
		near("count", e, tol, v);
	endtask

	task t_regs();
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h00, "ctrl reset");
		rd_chk(arb_pkg::ADDR_COUNT, 8'hFF, 8'h00, "count reset");
		reg_wr(2'h3, 8'hFF);
		reg_wr(arb_pkg::ADDR_COUNT, 8'h55);
		rd_chk(2'h2, 8'hFF, 8'h00, "unmapped");
		rd_chk(arb_pkg::ADDR_COUNT, 8'hFF, 8'h00, "count ro");
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h00, "ctrl kept");
		reg_wr(arb_pkg::ADDR_CTRL, 8'hC0);
		bus_partner_inst.set_dom(1'b1);
		cyc(20);
		rd_chk(arb_pkg::ADDR_COUNT, 8'hFF, 8'h00, "count rsvd");
		rd_chk(arb_pkg::ADDR_CTRL, 8'hF8, 8'hC0, "ctrl rsvd");
		bus_partner_inst.set_dom(1'b0);
		reg_wr(arb_pkg::ADDR_CTRL, 8'h00);
		$display("test regs done");
	endtask
	task t_meas0();
		reg_wr(arb_pkg::ADDR_CTRL, 8'h40);
		cyc(10);
		bus_partner_inst.set_dom(1'b1);
		cyc(10);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h48, "ctrl running");
		bus_partner_inst.set_dom(1'b0);
		cyc(80);
		bus_partner_inst.set_dom(1'b1);
		cyc(20);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h50, "ctrl done");
		rd_near(47, 2);
		bus_partner_inst.set_dom(1'b0);
		$display("test measure cs0 done");
	endtask
	task t_meas1();
		bus_partner_inst.set_dom(1'b1);
		cyc(10);
		reg_wr(arb_pkg::ADDR_CTRL, 8'h60);
		cyc(200);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h68, "ctrl break run");
		cyc(198);
		bus_partner_inst.set_dom(1'b0);
		cyc(20);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h70, "ctrl break done");
		rd_near(10, 1);
		reg_wr(arb_pkg::ADDR_CTRL, 8'h00);
		$display("test measure cs1 done");
	endtask
	task t_ovf();
		reg_wr(arb_pkg::ADDR_CTRL, 8'h40);
		bus_partner_inst.set_dom(1'b1);
		cyc(600);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h4A, "ctrl top bit");
		rd_near(45, 3);
		cyc(500);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h4C, "ctrl overflow");
		rd_near(41, 3);
		reg_wr(arb_pkg::ADDR_CTRL, 8'h00);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h00, "ctrl cleared");
		rd_chk(arb_pkg::ADDR_COUNT, 8'hFF, 8'h00, "count cleared");
		cyc(20);
		rd_chk(arb_pkg::ADDR_COUNT, 8'hFF, 8'h00, "count idle");
		bus_partner_inst.set_dom(1'b0);
		$display("test overflow done");
	endtask
	task t_arb(input logic [7:0] c, input int early, input int late);
		reg_wr(arb_pkg::ADDR_CTRL, c);
		bus_partner_inst.set_tx(1'b0);
		bus_partner_inst.set_tx(1'b1);
		cyc(10);
		bus_partner_inst.set_dom(1'b1);
		cyc(early);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hE1, c, "lost early");
		cyc(late);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hE1, c | 8'h01, "lost set");
		bus_partner_inst.set_tx(1'b0);
		cyc(8);
		#1;
		check8("pin forced", 8'h01, {7'h00, txd_pin});
		reg_wr(arb_pkg::ADDR_CTRL, 8'h80);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hE1, 8'h81, "lost kept");
		reg_wr(arb_pkg::ADDR_CTRL, 8'h00);
		bus_partner_inst.set_dom(1'b0);
		cyc(8);
		rd_chk(arb_pkg::ADDR_CTRL, 8'hFF, 8'h00, "lost cleared");
		check8("pin follows", 8'h00, {7'h00, txd_pin});
		bus_partner_inst.set_tx(1'b1);
		$display("test arbitration lost done");
	endtask
	task t_restart();
		reg_wr(arb_pkg::ADDR_CTRL, 8'h80);
		bus_partner_inst.set_tx(1'b0);
		bus_partner_inst.set_tx(1'b1);
		cyc(30);
		bus_partner_inst.set_tx(1'b0);
		cyc(10);
		rd_chk(arb_pkg::ADDR_COUNT, 8'hFF, 8'h00, "count reset tx low");
		cyc(150);
		rd_chk(arb_pkg::ADDR_COUNT, 8'hFF, 8'h00, "count waits");
		rd_chk(arb_pkg::ADDR_CTRL, 8'hE1, 8'h80, "no loss");
		bus_partner_inst.set_tx(1'b1);
		cyc(40);
		rd_near(18, 3);
		reg_wr(arb_pkg::ADDR_CTRL, 8'h00);
		$display("test arbitration restart done");
	endtask

	initial begin
		clk = 1'b0;
		rstn <= 1'b0;
		addr <= 2'h0;
		wdata <= 8'h00;
		we <= 1'b0;
		re <= 1'b0;
		cyc(4);
		#1;
		check8("pin in reset", 8'h01, {7'h00, txd_pin});
		check8("rdata in reset", 8'h00, rdata);
		@(posedge clk);
		rstn <= 1'b1;
		cyc(4);
		t_regs();
		t_meas0();
		t_meas1();
		t_ovf();
		t_arb(8'h80, 60, 60);
		t_arb(8'hA0, 190, 200);
		t_restart();
		conclude();
	end
endmodule // serial_line_arbiter_timer_tb
`default_nettype wire
